/* debounced_wake_pkg.sv */
package debounced_wake_pkg;

  // ****************************************************
  // timing
  // ****************************************************
  localparam int CLK_KHZ          = 250000;
  localparam int TAP10_MS         = 32;
  localparam int TAP8_MS          = 8;
  localparam int TAP6_MS          = 2;
  localparam int TAP10_CYC        = TAP10_MS * CLK_KHZ;
  localparam int TAP8_CYC         = TAP8_MS * CLK_KHZ;
  localparam int TAP6_CYC         = TAP6_MS * CLK_KHZ;
  localparam int CNT_W            = 23;
  localparam int HOLD_TICKS       = 2;
  localparam int PORT_W           = 4;

  // ****************************************************
  // register map
  // ****************************************************
  localparam int       AXI_AW      = 8;
  localparam int       AXI_DW      = 32;
  localparam bit [7:0] OFF_CTRL    = 8'h00;
  localparam bit [7:0] OFF_PC_SET  = 8'h04;
  localparam bit [7:0] OFF_PC_OUT  = 8'h08;
  localparam bit [7:0] OFF_PC_IN   = 8'h0C;
  localparam bit [7:0] OFF_PD_SET  = 8'h10;
  localparam bit [7:0] OFF_PD_OUT  = 8'h14;
  localparam bit [7:0] OFF_PD_IN   = 8'h18;
  localparam bit [7:0] OFF_SENSE   = 8'h1C;
  localparam bit [7:0] OFF_STATUS  = 8'h20;

  // ****************************************************
  // fields and reset values
  // ****************************************************
  localparam int       SEL_W       = 2;
  localparam int       IRQEN_BIT   = 4;
  localparam int       MODE_BIT    = 4;
  localparam int       SENSE_D_LSB = 4;
  localparam bit [1:0] SEL_TAP10   = 2'h0;
  localparam bit [1:0] SEL_TAP8    = 2'h1;
  localparam bit [1:0] SEL_TAP6    = 2'h2;
  localparam bit [4:0] SETUP_RST   = 5'h10;
  localparam bit [7:0] SENSE_RST   = 8'h00;
  localparam bit [1:0] RESP_OKAY   = 2'h0;
  localparam bit [1:0] RESP_SLVERR = 2'h2;

endpackage

/* sync_2ff.sv */
`timescale 1ns/1ps
module sync_2ff #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // data
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta_q  <= '0;
      syncOut <= '0;
    end
    else
    begin
      meta_q  <= asyncIn;
      syncOut <= meta_q;
    end
  end

endmodule

/* port_debounce.sv */
`timescale 1ns/1ps
module port_debounce
  import debounced_wake_pkg::*;
#(
  parameter int WIDTH = debounced_wake_pkg::PORT_W
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // qualification inputs
  input  wire logic             tick,
  input  wire logic [WIDTH-1:0] sample,
  input  wire logic             senseClr,
  // result
  output logic                  changeFlag
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_QUAL = 3'b010,
    ST_DONE = 3'b100
  } deb_state_t;

  deb_state_t       state_q, state_d;
  logic [WIDTH-1:0] ref_q, ref_d;
  logic [WIDTH-1:0] cand_q, cand_d;
  logic [1:0]       cnt_q, cnt_d;

  function automatic logic atMostOne(input logic [WIDTH-1:0] v);
    atMostOne = ((v & (v - 1'b1)) == '0);
  endfunction

  always_comb
  begin
    state_d = state_q;
    ref_d   = ref_q;
    cand_d  = cand_q;
    cnt_d   = cnt_q;
    case (state_q)
      ST_IDLE:
      begin
        if (senseClr)
        begin
          ref_d = sample;
        end
        // one pin toggles, all the others low
        else if (sample != ref_q && atMostOne(sample) && atMostOne(sample ^ ref_q))
        begin
          cand_d  = sample;
          cnt_d   = 2'h0;
          state_d = ST_QUAL;
        end
      end
      ST_QUAL:
      begin
        if (sample != cand_q)
        begin
          state_d = ST_IDLE;
        end
        else if (tick)
        begin
          cnt_d = cnt_q + 2'h1;
          if (cnt_d == 2'(HOLD_TICKS))
          begin
            ref_d   = cand_q;
            state_d = ST_DONE;
          end
        end
      end
      ST_DONE:
      begin
        // ticks ignored here: prescaler keeps running while flag set
        if (senseClr)
        begin
          ref_d   = sample;
          state_d = ST_IDLE;
        end
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= ST_IDLE;
      ref_q   <= '0;
      cand_q  <= '0;
      cnt_q   <= 2'h0;
    end
    else
    begin
      state_q <= state_d;
      ref_q   <= ref_d;
      cand_q  <= cand_d;
      cnt_q   <= cnt_d;
    end
  end

  assign changeFlag = (state_q == ST_DONE);

endmodule

/* debounced_wake_port.sv */
`timescale 1ns/1ps
module debounced_wake_port
  import debounced_wake_pkg::*;
#(
  // build options
  parameter bit PC_IS_PORT   = 1'b1,
  parameter bit PD_IS_PORT   = 1'b1,
  parameter bit PC_PULL_OPT  = 1'b1,
  parameter bit PC_HOLD_OPT  = 1'b1,
  parameter bit PD_PULL_OPT  = 1'b1,
  // debounce tick periods in clocks
  parameter int TAP10_CYCLES = debounced_wake_pkg::TAP10_CYC,
  parameter int TAP8_CYCLES  = debounced_wake_pkg::TAP8_CYC,
  parameter int TAP6_CYCLES  = debounced_wake_pkg::TAP6_CYC
) (
  // clock and reset
  input  wire logic                                     clk,
  input  wire logic                                     sys_rst,
  // axi4-lite write address
  input  wire logic [debounced_wake_pkg::AXI_AW-1:0]    s_axi_awaddr,
  input  wire logic                                     s_axi_awvalid,
  output logic                                          s_axi_awready,
  // axi4-lite write data
  input  wire logic [debounced_wake_pkg::AXI_DW-1:0]    s_axi_wdata,
  input  wire logic [debounced_wake_pkg::AXI_DW/8-1:0]  s_axi_wstrb,
  input  wire logic                                     s_axi_wvalid,
  output logic                                          s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                                    s_axi_bresp,
  output logic                                          s_axi_bvalid,
  input  wire logic                                     s_axi_bready,
  // axi4-lite read
  input  wire logic [debounced_wake_pkg::AXI_AW-1:0]    s_axi_araddr,
  input  wire logic                                     s_axi_arvalid,
  output logic                                          s_axi_arready,
  output logic [debounced_wake_pkg::AXI_DW-1:0]         s_axi_rdata,
  output logic [1:0]                                    s_axi_rresp,
  output logic                                          s_axi_rvalid,
  input  wire logic                                     s_axi_rready,
  // port c pads
  input  wire logic [debounced_wake_pkg::PORT_W-1:0]    portCIn,
  output logic      [debounced_wake_pkg::PORT_W-1:0]    portCOut,
  output logic      [debounced_wake_pkg::PORT_W-1:0]    portCOe,
  output logic      [debounced_wake_pkg::PORT_W-1:0]    portCPullEn,
  output logic      [debounced_wake_pkg::PORT_W-1:0]    portCHoldEn,
  // port d pads
  input  wire logic [debounced_wake_pkg::PORT_W-1:0]    portDIn,
  output logic      [debounced_wake_pkg::PORT_W-1:0]    portDOut,
  output logic      [debounced_wake_pkg::PORT_W-1:0]    portDOe,
  output logic      [debounced_wake_pkg::PORT_W-1:0]    portDPullEn,
  // wake
  output logic                                          wakeRequest,
  output logic                                          irqRequest
);

  // ****************************************************
  // registers
  // ****************************************************
  logic [SEL_W-1:0]  clkSel_q, clkSel_d;
  logic              irqEn_q, irqEn_d;
  logic [4:0]        pcSetup_q, pcSetup_d;
  logic [4:0]        pdSetup_q, pdSetup_d;
  logic [PORT_W-1:0] pcLatch_q, pcLatch_d;
  logic [PORT_W-1:0] pdLatch_q, pdLatch_d;
  logic [7:0]        sense_q, sense_d;
  logic              senseClr_q, senseClr_d;

  // bus state
  logic              awHave_q, awHave_d;
  logic              wHave_q, wHave_d;
  logic [AXI_AW-1:0] awAddr_q, awAddr_d;
  logic [AXI_DW-1:0] wData_q, wData_d;
  logic              wLane_q, wLane_d;
  logic              bValid_q, bValid_d;
  logic [1:0]        bResp_q, bResp_d;
  logic              rValid_q, rValid_d;
  logic [1:0]        rResp_q, rResp_d;
  logic [AXI_DW-1:0] rData_q, rData_d;

  // pins and wake
  logic [PORT_W-1:0] pcOut_q, pcOut_d, pcOe_q, pcOe_d;
  logic [PORT_W-1:0] pcPull_q, pcPull_d, pcHold_q, pcHold_d;
  logic [PORT_W-1:0] pdOut_q, pdOut_d, pdOe_q, pdOe_d;
  logic [PORT_W-1:0] pdPull_q, pdPull_d;
  logic              wake_q, wake_d, irq_q, irq_d;

  // prescaler
  logic [CNT_W-1:0]  preCnt_q, preCnt_d;
  logic              tick_q, tick_d;

  logic [PORT_W-1:0] pcSync, pdSync;
  logic [PORT_W-1:0] pcSample, pdSample;
  logic              pcFlag, pdFlag;
  logic              doWrite;

  function automatic logic [PORT_W-1:0] readBack(input logic [PORT_W-1:0] pins,
                                                 input logic [PORT_W-1:0] latch,
                                                 input logic [PORT_W-1:0] dir);
    readBack = (pins & ~dir) | (latch & dir);
  endfunction

  function automatic logic [CNT_W-1:0] tapLimit(input logic [SEL_W-1:0] sel);
    case (sel)
      SEL_TAP8: tapLimit = CNT_W'(TAP8_CYCLES - 1);
      SEL_TAP6: tapLimit = CNT_W'(TAP6_CYCLES - 1);
      default:  tapLimit = CNT_W'(TAP10_CYCLES - 1);
    endcase
  endfunction

  // ****************************************************
  // pin synchronisers
  // ****************************************************
  sync_2ff #(.WIDTH(PORT_W)) u_syncC (
    .clk     (clk),
    .sys_rst (sys_rst),
    .asyncIn (portCIn),
    .syncOut (pcSync)
  );

  sync_2ff #(.WIDTH(PORT_W)) u_syncD (
    .clk     (clk),
    .sys_rst (sys_rst),
    .asyncIn (portDIn),
    .syncOut (pdSync)
  );

  // ****************************************************
  // debounce
  // ****************************************************
  // only sensed input pins; segment option idles the port
  assign pcSample = PC_IS_PORT ? (pcSync & sense_q[PORT_W-1:0] & ~pcSetup_q[PORT_W-1:0]) : '0;
  assign pdSample = PD_IS_PORT ? (pdSync & sense_q[SENSE_D_LSB+:PORT_W] & ~pdSetup_q[PORT_W-1:0]) : '0;

  port_debounce #(.WIDTH(PORT_W)) u_debC (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .tick       (tick_q),
    .sample     (pcSample),
    .senseClr   (senseClr_q),
    .changeFlag (pcFlag)
  );

  port_debounce #(.WIDTH(PORT_W)) u_debD (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .tick       (tick_q),
    .sample     (pdSample),
    .senseClr   (senseClr_q),
    .changeFlag (pdFlag)
  );

  // ****************************************************
  // bus, registers, pins: next values
  // ****************************************************
  assign doWrite = awHave_q && wHave_q && !bValid_q;

  always_comb
  begin
    clkSel_d   = clkSel_q;
    irqEn_d    = irqEn_q;
    pcSetup_d  = pcSetup_q;
    pdSetup_d  = pdSetup_q;
    pcLatch_d  = pcLatch_q;
    pdLatch_d  = pdLatch_q;
    sense_d    = sense_q;
    senseClr_d = 1'b0;
    awHave_d   = awHave_q;
    wHave_d    = wHave_q;
    awAddr_d   = awAddr_q;
    wData_d    = wData_q;
    wLane_d    = wLane_q;
    bValid_d   = bValid_q;
    bResp_d    = bResp_q;
    rValid_d   = rValid_q;
    rResp_d    = rResp_q;
    rData_d    = rData_q;

    // write channels taken in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      awHave_d = 1'b1;
      awAddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      wHave_d = 1'b1;
      wData_d = s_axi_wdata;
      wLane_d = s_axi_wstrb[0];
    end
    if (doWrite)
    begin
      awHave_d = 1'b0;
      wHave_d  = 1'b0;
      bValid_d = 1'b1;
      bResp_d  = RESP_OKAY;
      case (awAddr_q)
        OFF_CTRL:
        begin
          if (wLane_q)
          begin
            clkSel_d = wData_q[SEL_W-1:0];
            irqEn_d  = wData_q[IRQEN_BIT];
          end
        end
        OFF_PC_SET:   if (wLane_q) pcSetup_d = wData_q[4:0];
        OFF_PC_OUT:   if (wLane_q) pcLatch_d = wData_q[PORT_W-1:0];
        OFF_PD_SET:   if (wLane_q) pdSetup_d = wData_q[4:0];
        OFF_PD_OUT:   if (wLane_q) pdLatch_d = wData_q[PORT_W-1:0];
        OFF_SENSE:
        begin
          if (wLane_q)
          begin
            sense_d    = wData_q[7:0];
            senseClr_d = 1'b1;
          end
        end
        OFF_PC_IN, OFF_PD_IN, OFF_STATUS: bResp_d = RESP_OKAY;
        default:      bResp_d = RESP_SLVERR;
      endcase
    end
    if (bValid_q && s_axi_bready)
    begin
      bValid_d = 1'b0;
    end

    if (s_axi_arvalid && s_axi_arready)
    begin
      rValid_d = 1'b1;
      rResp_d  = RESP_OKAY;
      rData_d  = '0;
      case (s_axi_araddr)
        OFF_CTRL:   rData_d[IRQEN_BIT:0]  = {irqEn_q, 2'h0, clkSel_q};
        OFF_PC_SET: rData_d[4:0]          = pcSetup_q;
        OFF_PC_OUT: rData_d[PORT_W-1:0]   = pcLatch_q;
        OFF_PC_IN:  rData_d[PORT_W-1:0]   = readBack(pcSync, pcLatch_q, pcSetup_q[PORT_W-1:0]);
        OFF_PD_SET: rData_d[4:0]          = pdSetup_q;
        OFF_PD_OUT: rData_d[PORT_W-1:0]   = pdLatch_q;
        OFF_PD_IN:  rData_d[PORT_W-1:0]   = readBack(pdSync, pdLatch_q, pdSetup_q[PORT_W-1:0]);
        OFF_SENSE:  rData_d[7:0]          = sense_q;
        OFF_STATUS: rData_d[3:0]          = {irq_q, wake_q, pdFlag, pcFlag};
        default:    rResp_d               = RESP_SLVERR;
      endcase
    end
    else if (rValid_q && s_axi_rready)
    begin
      rValid_d = 1'b0;
    end
  end

  // prescaler tick, restarted on every clock select write
  always_comb
  begin
    preCnt_d = preCnt_q + CNT_W'(1);
    tick_d   = 1'b0;
    if (preCnt_q >= tapLimit(clkSel_q))
    begin
      preCnt_d = '0;
      tick_d   = 1'b1;
    end
    if (doWrite && awAddr_q == OFF_CTRL && wLane_q)
    begin
      preCnt_d = '0;
    end
  end

  always_comb
  begin
    // latch reaches only output pins; pulls off on outputs
    pcOut_d  = PC_IS_PORT ? (pcLatch_q & pcSetup_q[PORT_W-1:0]) : '0;
    pcOe_d   = PC_IS_PORT ? pcSetup_q[PORT_W-1:0] : '0;
    pcPull_d = (PC_IS_PORT && PC_PULL_OPT && pcSetup_q[MODE_BIT]) ? ~pcSetup_q[PORT_W-1:0] : '0;
    // hold device only exists alongside the pull-low option
    pcHold_d = (PC_IS_PORT && PC_PULL_OPT && PC_HOLD_OPT && !pcSetup_q[MODE_BIT]) ?
               ~pcSetup_q[PORT_W-1:0] : '0;
    pdOut_d  = PD_IS_PORT ? (pdLatch_q & pdSetup_q[PORT_W-1:0]) : '0;
    pdOe_d   = PD_IS_PORT ? pdSetup_q[PORT_W-1:0] : '0;
    pdPull_d = (PD_IS_PORT && PD_PULL_OPT && pdSetup_q[MODE_BIT]) ? ~pdSetup_q[PORT_W-1:0] : '0;
    wake_d   = pcFlag || pdFlag;
    irq_d    = (pcFlag || pdFlag) && irqEn_q;
  end

  // ****************************************************
  // state registers
  // ****************************************************
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      clkSel_q   <= SEL_TAP10;
      irqEn_q    <= 1'b0;
      pcSetup_q  <= SETUP_RST;
      pdSetup_q  <= SETUP_RST;
      pcLatch_q  <= '0;
      pdLatch_q  <= '0;
      sense_q    <= SENSE_RST;
      senseClr_q <= 1'b0;
      awHave_q   <= 1'b0;
      wHave_q    <= 1'b0;
      awAddr_q   <= '0;
      wData_q    <= '0;
      wLane_q    <= 1'b0;
      bValid_q   <= 1'b0;
      bResp_q    <= RESP_OKAY;
      rValid_q   <= 1'b0;
      rResp_q    <= RESP_OKAY;
      rData_q    <= '0;
      preCnt_q   <= '0;
      tick_q     <= 1'b0;
      pcOut_q    <= '0;
      pcOe_q     <= '0;
      pcPull_q   <= {PORT_W{PC_IS_PORT && PC_PULL_OPT}};
      pcHold_q   <= '0;
      pdOut_q    <= '0;
      pdOe_q     <= '0;
      pdPull_q   <= {PORT_W{PD_IS_PORT && PD_PULL_OPT}};
      wake_q     <= 1'b0;
      irq_q      <= 1'b0;
    end
    else
    begin
      clkSel_q   <= clkSel_d;
      irqEn_q    <= irqEn_d;
      pcSetup_q  <= pcSetup_d;
      pdSetup_q  <= pdSetup_d;
      pcLatch_q  <= pcLatch_d;
      pdLatch_q  <= pdLatch_d;
      sense_q    <= sense_d;
      senseClr_q <= senseClr_d;
      awHave_q   <= awHave_d;
      wHave_q    <= wHave_d;
      awAddr_q   <= awAddr_d;
      wData_q    <= wData_d;
      wLane_q    <= wLane_d;
      bValid_q   <= bValid_d;
      bResp_q    <= bResp_d;
      rValid_q   <= rValid_d;
      rResp_q    <= rResp_d;
      rData_q    <= rData_d;
      preCnt_q   <= preCnt_d;
      tick_q     <= tick_d;
      pcOut_q    <= pcOut_d;
      pcOe_q     <= pcOe_d;
      pcPull_q   <= pcPull_d;
      pcHold_q   <= pcHold_d;
      pdOut_q    <= pdOut_d;
      pdOe_q     <= pdOe_d;
      pdPull_q   <= pdPull_d;
      wake_q     <= wake_d;
      irq_q      <= irq_d;
    end
  end

  // ****************************************************
  // outputs
  // ****************************************************
  assign s_axi_awready = !awHave_q;
  assign s_axi_wready  = !wHave_q;
  assign s_axi_bvalid  = bValid_q;
  assign s_axi_bresp   = bResp_q;
  assign s_axi_arready = !rValid_q;
  assign s_axi_rvalid  = rValid_q;
  assign s_axi_rresp   = rResp_q;
  assign s_axi_rdata   = rData_q;
  assign portCOut      = pcOut_q;
  assign portCOe       = pcOe_q;
  assign portCPullEn   = pcPull_q;
  assign portCHoldEn   = pcHold_q;
  assign portDOut      = pdOut_q;
  assign portDOe       = pdOe_q;
  assign portDPullEn   = pdPull_q;
  assign wakeRequest   = wake_q;
  assign irqRequest    = irq_q;

endmodule

/* debounced_wake_port_monitor.sv */
`timescale 1ns/1ps
module debounced_wake_port_monitor (
  // clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // bus answers
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // pads and wake
  input wire logic [3:0]  portCOut,
  input wire logic [3:0]  portCOe,
  input wire logic [3:0]  portCPullEn,
  input wire logic [3:0]  portCHoldEn,
  input wire logic [3:0]  portDOut,
  input wire logic [3:0]  portDOe,
  input wire logic [3:0]  portDPullEn,
  input wire logic        wakeRequest,
  input wire logic        irqRequest
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_pd_pull_off: assert property (!(portDPullEn & portDOe))
    else $error("port d pull on while driving");
  a_pc_pull_off: assert property (!(portCPullEn & portCOe))
    else $error("port c pull on while driving");
  a_pc_hold_off: assert property (!(portCHoldEn & portCOe))
    else $error("port c hold on while driving");
  a_pd_out_gate: assert property (!(portDOut & ~portDOe))
    else $error("port d latch on input pin");
  a_pc_out_gate: assert property (!(portCOut & ~portCOe))
    else $error("port c latch on input pin");
  a_irq_needs_wake: assert property (irqRequest |-> wakeRequest)
    else $error("irq without wake");
  a_wake_release: assert property ($fell(wakeRequest) |->
    $past(s_axi_bvalid) || $past(s_axi_bvalid, 2) || $past(s_axi_bvalid, 3) || $past(s_axi_bvalid, 4))
    else $error("wake dropped without a write");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer not held");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer not held");
  c_wake: cover property ($rose(wakeRequest));
  c_irq: cover property ($rose(irqRequest));
  c_err: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule

bind debounced_wake_port debounced_wake_port_monitor mon (.clk, .sys_rst, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .portCOut, .portCOe, .portCPullEn,
  .portCHoldEn, .portDOut, .portDOe, .portDPullEn, .wakeRequest, .irqRequest);

/* key_pad_model.sv */
`timescale 1ns/1ps
module key_pad_model (
  // clock
  input wire logic       clk,
  // keys and pad controls
  input wire logic [3:0] keys,
  input wire logic [3:0] oe,
  input wire logic [3:0] drive,
  input wire logic [3:0] pull,
  input wire logic [3:0] hold,
  // pin levels
  output logic     [3:0] level
);
  logic floatQ;
  initial floatQ = 1'b0;
  // a floating pin wanders instead of keeping its last level
  always @(posedge clk)
  begin
    floatQ <= ~floatQ;
  end
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      level[i] = oe[i] ? drive[i] : keys[i] ? 1'b1 : (pull[i] | hold[i]) ? 1'b0 : floatQ;
    end
  end
endmodule

/* debounced_wake_port_bench.sv */
`timescale 1ns/1ps
module debounced_wake_port_bench;
  import debounced_wake_pkg::*;
  logic        clk, sys_rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, wake, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, got;
  logic [1:0]  bresp, rresp;
  logic [3:0]  cIn, cOut, cOe, cPull, cHold, dIn, dOut, dOe, dPull, keyC, keyD;
  int          fail_count, compares, n;

  debounced_wake_port #(.TAP10_CYCLES(40), .TAP8_CYCLES(20), .TAP6_CYCLES(10)) dut (
    .clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .portCIn(cIn),
    .portCOut(cOut), .portCOe(cOe), .portCPullEn(cPull), .portCHoldEn(cHold), .portDIn(dIn),
    .portDOut(dOut), .portDOe(dOe), .portDPullEn(dPull), .wakeRequest(wake), .irqRequest(irq));
  key_pad_model padC (.clk(clk), .keys(keyC), .oe(cOe), .drive(cOut), .pull(cPull), .hold(cHold),
    .level(cIn));
  key_pad_model padD (.clk(clk), .keys(keyD), .oe(dOe), .drive(dOut), .pull(dPull), .hold(4'h0),
    .level(dIn));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ****************************************************
  // shared tasks
  // ****************************************************
  task automatic conclude();
    $display("checks %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic hang();
    fail_count++;
    conclude();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
    int i;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
      if (bvalid) bready <= 1'b1;
    end
    if (i == 50) hang();
    chk(bresp, resp);
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] resp, output logic [31:0] d);
    int i;
    araddr <= a;
    arvalid <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
      if (rvalid) rready <= 1'b1;
    end
    if (i == 50) hang();
    chk(rresp, resp);
    d = rdata;
    rready <= 1'b0;
    @(posedge clk);
  endtask
  // counts cycles until wake, stops at the limit
  task automatic waitWake(input int lim, output int cyc);
    for (cyc = 0; cyc < lim; cyc++)
    begin
      @(posedge clk);
      if (wake === 1'b1) break;
    end
  endtask

  // ****************************************************
  // scenarios
  // ****************************************************
  task automatic s_reset();
    chk(cOe, 4'h0);
    chk(dOe, 4'h0);
    chk({cPull, cHold}, 8'hF0);
    chk(dPull, 4'hF);
    rd(OFF_CTRL, RESP_OKAY, got);
    chk(got, 32'h0);
    rd(OFF_PC_SET, RESP_OKAY, got);
    chk(got, 32'h10);
    rd(OFF_SENSE, RESP_OKAY, got);
    chk(got, 32'h0);
    rd(8'h40, RESP_SLVERR, got);
    chk(got, 32'h0);
    wr(8'h40, 32'h1, RESP_SLVERR);
  endtask
  task automatic s_port_d();
    wr(OFF_PD_OUT, 32'h5, RESP_OKAY);
    wr(OFF_PD_SET, 32'h13, RESP_OKAY);
    keyD <= 4'hA;
    repeat (4) @(posedge clk);
    chk({dOut, dOe, dPull}, 12'h13C);
    rd(OFF_PD_IN, RESP_OKAY, got);
    chk(got, 32'h9);
    wr(OFF_PD_SET, 32'h03, RESP_OKAY);
    chk(dPull, 4'h0);
    wr(OFF_PD_SET, 32'h10, RESP_OKAY);
    keyD <= 4'h0;
  endtask
  task automatic s_port_c();
    logic [7:0]  setv [4] = '{8'h00, 8'h10, 8'h11, 8'h01};
    logic [15:0] expv [4] = '{16'h000F, 16'h00F0, 16'h11E0, 16'h110E};
    wr(OFF_PC_OUT, 32'hF, RESP_OKAY);
    for (int i = 0; i < 4; i++)
    begin
      wr(OFF_PC_SET, {24'h0, setv[i]}, RESP_OKAY);
      chk({cOut, cOe, cPull, cHold}, expv[i]);
    end
    wr(OFF_PC_SET, 32'h10, RESP_OKAY);
    wr(OFF_PC_OUT, 32'h0, RESP_OKAY);
  endtask
  task automatic s_wake_d();
    wr(OFF_CTRL, 32'h10, RESP_OKAY);
    wr(OFF_SENSE, 32'h10, RESP_OKAY);
    keyD <= 4'h1;
    waitWake(200, n);
    chk(n > 40 && n <= 90, 1'b1);
    chk(irq, 1'b1);
    rd(OFF_PD_IN, RESP_OKAY, got);
    chk(got, 32'h1);
    rd(OFF_STATUS, RESP_OKAY, got);
    chk(got, 32'hE);
    keyD <= 4'h0;
    wr(OFF_SENSE, 32'h01, RESP_OKAY);
    repeat (4) @(posedge clk);
    chk({wake, irq}, 2'h0);
  endtask
  task automatic s_wake_c();
    wr(OFF_CTRL, {30'h0, SEL_TAP6}, RESP_OKAY);
    keyC <= 4'h1;
    waitWake(200, n);
    chk(n > 10 && n <= 30, 1'b1);
    chk(irq, 1'b0);
    rd(OFF_STATUS, RESP_OKAY, got);
    chk(got, 32'h5);
    keyC <= 4'h0;
    wr(OFF_SENSE, 32'h03, RESP_OKAY);
    keyC <= 4'h3;
    waitWake(80, n);
    chk(n, 80);
    keyC <= 4'h0;
    wr(OFF_SENSE, 32'h02, RESP_OKAY);
    keyC <= 4'h1;
    waitWake(80, n);
    chk(n, 80);
    keyC <= 4'h0;
    wr(OFF_CTRL, {30'h0, SEL_TAP8}, RESP_OKAY);
    wr(OFF_SENSE, 32'h01, RESP_OKAY);
    keyC <= 4'h1;
    waitWake(200, n);
    chk(n > 20 && n <= 50, 1'b1);
    keyC <= 4'h0;
  endtask

  initial
  begin
    sys_rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata} = 48'h0;
    {keyC, keyD} = 8'h0;
    fail_count = 0;
    compares = 0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    s_reset();
    s_port_d();
    s_port_c();
    s_wake_d();
    s_wake_c();
    conclude();
  end
endmodule
